// >>> pkg/ouv_defines.svh
`ifndef OUV_DEFINES_SVH
`define OUV_DEFINES_SVH
`define OUV_IDX_OPT_A 8'h1F
`define OUV_IDX_STATUS 8'h20
`define OUV_IDX_OPT_B 8'h21
`define OUV_ADDR_W 12
`define OUV_ADDR_OPT_A 12'h07C
`define OUV_ADDR_STATUS 12'h080
`define OUV_ADDR_OPT_B 12'h084
`define OUV_FLAG_BIT 0
`define OUV_WAKE_W 13
`define OUV_WAKE_SHORT 13'h0020
`define OUV_WAKE_LONG 13'h1000
`define OUV_WDOG_W 19
`define OUV_WDOG_SHORT 19'h0_1FF0
`define OUV_WDOG_LONG 19'h3_FFF0
`endif

// >>> pkg/ouv_pkg.sv
package ouv_pkg;
  // primary option byte, msb first
  typedef struct packed {
    logic stop_en;
    logic read_protect;
    logic rst_en;
    logic pwr_en;
    logic short_wake;
    logic wdog_short;
    logic stop_instr_en;
    logic wdog_disable;
  } ouv_option_config_primary_s;
  // secondary option byte
  typedef struct packed {
    logic [5:0] unused;
    logic eeprom_bus_clk;
    logic variant;
  } ouv_option_config_secondary_s;
endpackage : ouv_pkg

// >>> core/ouv_ctrl.sv
`timescale 1ns/1ns
`include "ouv_defines.svh"
module ouv_ctrl #(
  parameter ouv_pkg::ouv_option_config_primary_s OPT_A = 8'h50,
  // variant value is arbitrary
  parameter ouv_pkg::ouv_option_config_secondary_s OPT_B = 8'h0_0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`OUV_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_below_falling,
  input wire logic supply_above_rising,
  input wire logic wait_mode,
  input wire logic stop_mode,
  output logic chip_reset_req,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n,
  output logic prog_read_block,
  output logic [`OUV_WAKE_W-1:0] wake_delay,
  output logic [`OUV_WDOG_W-1:0] wdog_period,
  output logic stop_illegal,
  output logic wdog_run,
  output logic eeprom_clk_bus
);
  import ouv_pkg::*;

  // ----------------------------------------
  // monitor
  // ----------------------------------------
  // no enable register: options and stop mode decide
  wire logic mon_active;
  assign mon_active = OPT_A.pwr_en &&
    (!stop_mode || OPT_A.stop_en);

  wire logic trip;
  assign trip = mon_active &&
    supply_below_falling;

  wire logic recover;
  assign recover = mon_active &&
    supply_above_rising;

  wire logic rst_trip;
  assign rst_trip = trip && OPT_A.rst_en;

  logic flag;
  logic next_flag;
  logic next_hold;

  always_comb begin
    next_flag = flag;
    if (trip) begin
      next_flag = 1'b1;
    end else if (recover) begin
      next_flag = 1'b0;
    end
  end

  // release only on the rising level, so a
  // supply sitting between levels stays held
  always_comb begin
    next_hold = chip_reset_req;
    if (rst_trip) begin
      next_hold = 1'b1;
    end else if (supply_above_rising) begin
      next_hold = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
      chip_reset_req <= 1'b0;
      reset_pin_oe_n <= 1'b1;
    end else begin
      flag <= next_flag;
      // reset only: no interrupt path exists
      chip_reset_req <= next_hold;
      reset_pin_oe_n <= !next_hold;
    end
  end

  // ----------------------------------------
  // option decode
  // ----------------------------------------
  // options are constants; flops only keep
  // outputs registered, reset does not alter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pin_out <= 1'b0;
      prog_read_block <= OPT_A.read_protect;
      wake_delay <= OPT_A.short_wake ?
        `OUV_WAKE_SHORT : `OUV_WAKE_LONG;
      wdog_period <= OPT_A.wdog_short ?
        `OUV_WDOG_SHORT : `OUV_WDOG_LONG;
      stop_illegal <= !OPT_A.stop_instr_en;
      wdog_run <= !OPT_A.wdog_disable;
      eeprom_clk_bus <= OPT_B.eeprom_bus_clk;
    end else begin
      reset_pin_out <= 1'b0;
      prog_read_block <= OPT_A.read_protect;
      wake_delay <= OPT_A.short_wake ?
        `OUV_WAKE_SHORT : `OUV_WAKE_LONG;
      wdog_period <= OPT_A.wdog_short ?
        `OUV_WDOG_SHORT : `OUV_WDOG_LONG;
      stop_illegal <= !OPT_A.stop_instr_en;
      wdog_run <= !OPT_A.wdog_disable;
      eeprom_clk_bus <= OPT_B.eeprom_bus_clk;
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  function automatic logic [1:0] reg_sel(
    input logic [`OUV_ADDR_W-1:0] a
  );
    reg_sel = 2'd3;
    case (a)
      `OUV_ADDR_OPT_A: reg_sel = 2'd0;
      `OUV_ADDR_STATUS: reg_sel = 2'd1;
      `OUV_ADDR_OPT_B: reg_sel = 2'd2;
      default: reg_sel = 2'd3;
    endcase
  endfunction : reg_sel

  wire logic access;
  assign access = psel && penable && !pready;

  wire logic [1:0] sel;
  assign sel = reg_sel(paddr);

  wire logic [7:0] status_byte;
  assign status_byte = {7'h0, flag};

  wire logic [7:0] rd_byte;
  assign rd_byte =
    (sel == 2'd0) ? OPT_A :
    (sel == 2'd1) ? status_byte :
    (sel == 2'd2) ? OPT_B :
    8'h0_0;

  // writes have no target: all bits are fixed
  wire logic [31:0] next_prdata;
  assign next_prdata = (access && !pwrite) ?
    {24'h00_0000, rd_byte} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access && (sel == 2'd3);
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_flag_set;
    trip |=> flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag missed trip");

  property p_flag_clr;
    recover && !trip |=> !flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("flag not cleared");

  property p_flag_hold;
    !trip && !recover |=> $stable(flag);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag moved between levels");

  property p_rst_trip;
    OPT_A.pwr_en && OPT_A.rst_en && !stop_mode &&
      supply_below_falling |=> chip_reset_req;
  endproperty
  a_rst_trip: assert property (p_rst_trip)
    else $error("no reset on trip");

  property p_rst_held;
    chip_reset_req && !supply_above_rising
      |=> chip_reset_req;
  endproperty
  a_rst_held: assert property (p_rst_held)
    else $error("reset released early");

  property p_pin;
    chip_reset_req |-> !reset_pin_oe_n &&
      !reset_pin_out;
  endproperty
  a_pin: assert property (p_pin)
    else $error("reset pin not driven");

  property p_stop_off;
    stop_mode && !OPT_A.stop_en &&
      !chip_reset_req ##1 stop_mode
      |-> !chip_reset_req;
  endproperty
  a_stop_off: assert property (p_stop_off)
    else $error("monitor active in stop");

  property p_ro_read;
    access ##1 pready && !pwrite &&
      (paddr == `OUV_ADDR_OPT_A)
      |-> prdata[7:0] == OPT_A;
  endproperty
  a_ro_read: assert property (p_ro_read)
    else $error("option read wrong");

  property p_wake;
    wake_delay == (OPT_A.short_wake ?
      `OUV_WAKE_SHORT : `OUV_WAKE_LONG);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake delay wrong");

  property p_wdog;
    wdog_run == !OPT_A.wdog_disable &&
      wdog_period == (OPT_A.wdog_short ?
      `OUV_WDOG_SHORT : `OUV_WDOG_LONG);
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog setting wrong");

  property p_ready;
    access |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("bus answer timing wrong");

  c_trip: cover property (rst_trip ##1 chip_reset_req);
  c_release: cover property (
    chip_reset_req ##1 !chip_reset_req);
  c_poll: cover property (
    pready && !pwrite && flag &&
    (paddr == `OUV_ADDR_STATUS));
  c_write: cover property (pready && pwrite);

endmodule : ouv_ctrl

// >>> testbench/ouv_ctrl_test.sv
`timescale 1ns/1ns
module ouv_ctrl_test;
  import ouv_pkg::*;
  // ----------------------------------------
  // signals and device
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, rst_req, pin_out, pin_oe_n, pin_level;
  logic below = 1'b0;
  logic above = 1'b0;
  logic wait_m = 1'b0;
  logic stop_m = 1'b0;
  logic rd_blk, stop_ill, wd_run, ee_bus;
  logic [12:0] wake;
  logic [18:0] wdp;
  logic [31:0] poll_prdata;
  logic poll_rst;
  int error_cnt = 0;
  int comparisons = 0;

  // pulled up pin, low only while driven
  assign pin_level = pin_oe_n ? 1'b1 : pin_out;

  // variant value is arbitrary
  ouv_ctrl #(.OPT_A(8'h35), .OPT_B(8'h02)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_below_falling(below),
    .supply_above_rising(above), .wait_mode(wait_m), .stop_mode(stop_m),
    .chip_reset_req(rst_req), .reset_pin_in(pin_level),
    .reset_pin_out(pin_out), .reset_pin_oe_n(pin_oe_n),
    .prog_read_block(rd_blk), .wake_delay(wake), .wdog_period(wdp),
    .stop_illegal(stop_ill), .wdog_run(wd_run), .eeprom_clk_bus(ee_bus)
  );

  // polled supervision: power on, resets off, stop enable clear
  ouv_ctrl #(.OPT_A(8'h14), .OPT_B(8'h00)) i_poll (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(poll_prdata),
    .pready(), .pslverr(), .supply_below_falling(below),
    .supply_above_rising(above), .wait_mode(wait_m), .stop_mode(stop_m),
    .chip_reset_req(poll_rst), .reset_pin_in(1'b1),
    .reset_pin_out(), .reset_pin_oe_n(),
    .prog_read_block(), .wake_delay(), .wdog_period(),
    .stop_illegal(), .wdog_run(), .eeprom_clk_bus()
  );

  initial begin
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task apb(input logic [11:0] a, input logic w, input logic [31:0] exp,
           input logic err);
    int n;
    n = 0;
    // idle edge first, so psel is never assigned twice in one step
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'hFFFF_FFFF;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk("pready", 32'h0000_0001, 32'(pready));
    if (!w) chk("prdata", exp, prdata);
    if (!w && a == 12'h080) chk("poll_flag", exp, poll_prdata);
    chk("pslverr", 32'(err), 32'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task mon(input logic b, input logic a, input logic w, input logic s,
           input logic exp_rst);
    @(posedge pclk);
    below <= b;
    above <= a;
    wait_m <= w;
    stop_m <= s;
    @(posedge pclk);
    #1;
    chk("chip_reset_req", 32'(exp_rst), 32'(rst_req));
    chk("reset_pin_oe_n", 32'(!exp_rst), 32'(pin_oe_n));
    chk("poll_reset", 32'h0000_0000, 32'(poll_rst));
  endtask : mon

  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    #1;
    chk("chip_reset_req", 32'h0000_0000, 32'(rst_req));
    chk("reset_pin_oe_n", 32'h0000_0001, 32'(pin_oe_n));
    chk("prog_read_block", 32'h0000_0000, 32'(rd_blk));
    chk("wake_delay", 32'h0000_1000, 32'(wake));
    chk("wdog_period", 32'h0000_1FF0, 32'(wdp));
    chk("stop_illegal", 32'h0000_0001, 32'(stop_ill));
    chk("wdog_run", 32'h0000_0000, 32'(wd_run));
    chk("eeprom_clk_bus", 32'h0000_0001, 32'(ee_bus));
    @(posedge pclk);
    presetn <= 1'b1;
    apb(12'h07C, 1'b0, 32'h0000_0035, 1'b0);
    apb(12'h07C, 1'b1, 32'h0000_0000, 1'b0);
    apb(12'h084, 1'b1, 32'h0000_0000, 1'b0);
    apb(12'h07C, 1'b0, 32'h0000_0035, 1'b0);
    apb(12'h084, 1'b0, 32'h0000_0002, 1'b0);
    apb(12'h088, 1'b0, 32'h0000_0000, 1'b1);
    apb(12'h080, 1'b0, 32'h0000_0000, 1'b0);
    mon(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    chk("reset_pin_out", 32'h0000_0000, 32'(pin_level));
    apb(12'h080, 1'b0, 32'h0000_0001, 1'b0);
    mon(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    apb(12'h080, 1'b0, 32'h0000_0001, 1'b0);
    mon(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    apb(12'h080, 1'b0, 32'h0000_0000, 1'b0);
    mon(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    mon(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    // stop enable option is clear, so no trip in stop mode
    mon(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    apb(12'h080, 1'b0, 32'h0000_0000, 1'b0);
    mon(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    mon(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    below <= 1'b0;
    @(posedge pclk);
    #1;
    chk("chip_reset_req", 32'h0000_0000, 32'(rst_req));
    @(posedge pclk);
    presetn <= 1'b1;
    apb(12'h080, 1'b0, 32'h0000_0000, 1'b0);
    conclude();
  end

  initial begin
    repeat (3000) @(posedge pclk);
    error_cnt++;
    conclude();
  end
endmodule : ouv_ctrl_test
